// ### cssel_pkg.sv
package cssel_pkg;

  // ==========================================================================
  // clock source select fuse codes
  localparam logic [3:0] CKSRC_EXT_CLK   = 4'h0;
  localparam logic [3:0] CKSRC_INT_RC_LO = 4'h1;
  localparam logic [3:0] CKSRC_INT_RC_HI = 4'h4;
  localparam logic [3:0] CKSRC_EXT_RC_LO = 4'h5;
  localparam logic [3:0] CKSRC_EXT_RC_HI = 4'h8;
  localparam logic [3:0] CKSRC_LF_XTAL   = 4'h9;

  // ==========================================================================
  // startup time select codes
  localparam logic [1:0] SUT_00 = 2'h0;
  localparam logic [1:0] SUT_01 = 2'h1;
  localparam logic [1:0] SUT_10 = 2'h2;
  localparam logic [1:0] SUT_11 = 2'h3;

  // ==========================================================================
  // start-up counts in source clocks, reset delay counts in watchdog cycles
  localparam int SU_CK_6   = 6;
  localparam int SU_CK_18  = 18;
  localparam int SU_CK_1K  = 1024;
  localparam int SU_CK_32K = 32768;
  localparam int DLY_CK_4K  = 4096;
  localparam int DLY_CK_64K = 65536;

  // ==========================================================================
  // timing: watchdog oscillator timebase derived from the system clock
  localparam int CLK_PERIOD_NS     = 10;
  localparam int WDT_OSC_PERIOD_NS = 1000;
  localparam int WDT_DIV           = WDT_OSC_PERIOD_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // register map
  localparam logic [3:0] REG_TRIM   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_FUSE   = 4'h2;
  localparam logic [7:0] TRIM_RST   = 8'h00;

  // status register fields
  localparam int ST_READY_BIT = 0;
  localparam int ST_RSVD_BIT  = 1;
  localparam int ST_MODE_LSB  = 2;
  localparam int ST_WAKE_BIT  = 5;
  localparam int ST_SLEEP_BIT = 6;
  localparam int ST_RDLY_BIT  = 7;

  typedef enum logic [2:0] {
    SRC_EXT_CLK,
    SRC_INT_RC,
    SRC_EXT_RC,
    SRC_LF_XTAL,
    SRC_XTAL
  } cssel_src_t;

endpackage : cssel_pkg

// ### cssel_tick_div.sv
`timescale 1ns/100ps
`default_nettype none

// one-cycle enable every DIV clocks
module cssel_tick_div #(
  parameter int DIV = 100
) (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  output logic      tick_o
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         wrap;

  assign wrap    = (cnt_ff == LAST);
  assign nxt_cnt = wrap ? '0 : cnt_ff + W'(1);
  assign tick_o  = wrap;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : cssel_tick_div

`default_nettype wire

// ### cssel_down_cnt.sv
`timescale 1ns/100ps
`default_nettype none

// loadable down counter, steps on tick, parks at zero
module cssel_down_cnt #(
  parameter int W = 17
) (
  input  wire logic         clock_i,
  input  wire logic         nrst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         tick_i,
  output logic              done_o,
  output logic [W-1:0]      count_o
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  assign nxt_cnt = load_i ? load_val_i :
                   (tick_i && (cnt_ff != '0)) ? cnt_ff - W'(1) : cnt_ff;
  assign done_o  = (cnt_ff == '0) && !load_i;
  assign count_o = cnt_ff;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : cssel_down_cnt

`default_nettype wire

// ### cssel_clock_source_startup_select.sv
// Operation
// - fuse code 1001 selects the low-frequency watch crystal source
// - watch crystal: 1K or 32K start-up, 4.1ms/65ms delay, select 11 reserved
// - codes 0101..1000 select external RC, one of four frequency ranges
// - external RC: 18 clocks with none/4.1ms/65ms delay, 11 gives 6 clocks+4.1ms
// - codes 0001..0100 select internal RC at 1, 2, 4 or 8 MHz
// - every reset loads factory calibration byte into the trim register
// - internal RC: 6 clocks with none/4.1ms/65ms delay, select 11 reserved
// - watchdog and reset delay always run from the watchdog oscillator
// - trim zero is slowest, larger is faster, ff is fastest
// - trim 00/7f/ff give 50-100, 75-150, 100-200 percent of nominal
// - fuse code 0000 selects the external clock on the crystal input pin
// - external clock: 6 clocks with none/4.1ms/65ms delay, 11 reserved
// - internal RC frees both crystal pins for gpio or timer oscillator
// - reset delay counts 4K or 64K watchdog cycles
// - wake from power-down/save counts source clocks before resuming
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module cssel_clock_source_startup_select #(
  parameter int SU_LONG_CK    = cssel_pkg::SU_CK_32K,
  parameter int DLY_SHORT_CK  = cssel_pkg::DLY_CK_4K,
  parameter int DLY_LONG_CK   = cssel_pkg::DLY_CK_64K,
  parameter int WDT_DIV       = cssel_pkg::WDT_DIV,
  parameter int CNT_W         = 17,
  parameter int ADDR_W        = 4
) (
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  input  wire logic [3:0]        clock_source_select_i,
  input  wire logic [1:0]        startup_time_select_i,
  input  wire logic [7:0]        factory_trim_i,
  input  wire logic              source_tick_i,
  input  wire logic              sleep_req_i,
  input  wire logic              wake_req_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  output logic                   core_clk_en_o,
  output logic      [7:0]        trim_value_o,
  output logic      [2:0]        source_mode_o,
  output logic      [1:0]        freq_range_o,
  output logic                   xtal_pins_free_o,
  output logic                   wdt_tick_o,
  output logic                   cfg_reserved_o
);

  // ==========================================================================
  // state
  // sample and load each last one cycle after reset
  typedef enum logic [2:0] {
    ST_SAMPLE,
    ST_LOAD,
    ST_RESET_WAIT,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } cssel_state_t;

  // one width for every count, sized by the 64K reset delay
  localparam logic [CNT_W-1:0] CNT_NONE  = '0;
  localparam logic [CNT_W-1:0] CNT_6     = CNT_W'(cssel_pkg::SU_CK_6);
  localparam logic [CNT_W-1:0] CNT_18    = CNT_W'(cssel_pkg::SU_CK_18);
  localparam logic [CNT_W-1:0] CNT_1K    = CNT_W'(cssel_pkg::SU_CK_1K);
  localparam logic [CNT_W-1:0] CNT_32K   = CNT_W'(SU_LONG_CK);
  localparam logic [CNT_W-1:0] CNT_DLY_S = CNT_W'(DLY_SHORT_CK);
  localparam logic [CNT_W-1:0] CNT_DLY_L = CNT_W'(DLY_LONG_CK);

  cssel_state_t state_ff;
  cssel_state_t nxt_state;

  logic [3:0]  clock_source_select_ff;
  logic [1:0]  sut_ff;
  logic [7:0]  trim_ff;
  logic [7:0]  nxt_trim;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;

  // ==========================================================================
  // source decode from the sampled fuses
  logic is_ext_clk;
  logic is_int_rc;
  logic is_ext_rc;
  logic is_lf_xtal;
  logic is_xtal;
  cssel_pkg::cssel_src_t src_mode;

  assign is_ext_clk = (clock_source_select_ff == cssel_pkg::CKSRC_EXT_CLK);
  assign is_int_rc  = (clock_source_select_ff >= cssel_pkg::CKSRC_INT_RC_LO) &&
                      (clock_source_select_ff <= cssel_pkg::CKSRC_INT_RC_HI);
  assign is_ext_rc  = (clock_source_select_ff >= cssel_pkg::CKSRC_EXT_RC_LO) &&
                      (clock_source_select_ff <= cssel_pkg::CKSRC_EXT_RC_HI);
  assign is_lf_xtal = (clock_source_select_ff == cssel_pkg::CKSRC_LF_XTAL);
  // the rest are high-frequency crystal codes, not built here and flagged
  assign is_xtal    = !(is_ext_clk || is_int_rc || is_ext_rc || is_lf_xtal);

  assign src_mode = is_ext_clk ? cssel_pkg::SRC_EXT_CLK :
                    is_int_rc  ? cssel_pkg::SRC_INT_RC  :
                    is_ext_rc  ? cssel_pkg::SRC_EXT_RC  :
                    is_lf_xtal ? cssel_pkg::SRC_LF_XTAL : cssel_pkg::SRC_XTAL;

  // range index: ext rc band or internal rc nominal 1/2/4/8 MHz
  logic [3:0] int_rc_idx;
  logic [3:0] ext_rc_idx;

  assign int_rc_idx = clock_source_select_ff - cssel_pkg::CKSRC_INT_RC_LO;
  assign ext_rc_idx = clock_source_select_ff - cssel_pkg::CKSRC_EXT_RC_LO;
  assign freq_range_o = is_int_rc ? int_rc_idx[1:0] :
                        is_ext_rc ? ext_rc_idx[1:0] : 2'h0;

  // crystal pins are only released when nothing external clocks the chip
  assign xtal_pins_free_o = is_int_rc;

  // ==========================================================================
  // start-up and reset delay selection
  logic [CNT_W-1:0] su_cnt;
  logic [CNT_W-1:0] dly_cnt;
  logic             cfg_rsvd;

  // reserved and unsupported selections fall back to the slowest setting
  // of the mode so a mis-programmed part still starts conservatively
  always_comb begin
    su_cnt   = CNT_6;
    dly_cnt  = CNT_DLY_L;
    cfg_rsvd = 1'b0;
    case (src_mode)
      cssel_pkg::SRC_LF_XTAL: begin
        case (sut_ff)
          cssel_pkg::SUT_00: begin
            su_cnt  = CNT_1K;
            dly_cnt = CNT_DLY_S;
          end
          cssel_pkg::SUT_01: begin
            su_cnt  = CNT_1K;
            dly_cnt = CNT_DLY_L;
          end
          cssel_pkg::SUT_10: begin
            su_cnt  = CNT_32K;
            dly_cnt = CNT_DLY_L;
          end
          default: begin
            su_cnt   = CNT_32K;
            cfg_rsvd = 1'b1;
          end
        endcase
      end
      cssel_pkg::SRC_EXT_RC: begin
        su_cnt = CNT_18;
        case (sut_ff)
          cssel_pkg::SUT_00: dly_cnt = CNT_NONE;
          cssel_pkg::SUT_01: dly_cnt = CNT_DLY_S;
          cssel_pkg::SUT_10: dly_cnt = CNT_DLY_L;
          default: begin
            su_cnt  = CNT_6;
            dly_cnt = CNT_DLY_S;
          end
        endcase
      end
      cssel_pkg::SRC_INT_RC,
      cssel_pkg::SRC_EXT_CLK: begin
        su_cnt = CNT_6;
        case (sut_ff)
          cssel_pkg::SUT_00: dly_cnt = CNT_NONE;
          cssel_pkg::SUT_01: dly_cnt = CNT_DLY_S;
          cssel_pkg::SUT_10: dly_cnt = CNT_DLY_L;
          default:           cfg_rsvd = 1'b1;
        endcase
      end
      default: begin
        su_cnt   = CNT_32K;
        cfg_rsvd = 1'b1;
      end
    endcase
  end

  // ==========================================================================
  // counters: start-up on source clocks, reset delay on watchdog ticks
  logic su_load;
  logic dly_load;
  logic su_done;
  logic dly_done;
  logic wdt_tick;

  // watchdog timebase is independent of the chosen system source
  cssel_tick_div #(
    .DIV (WDT_DIV)
  ) u_wdt_div (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .tick_o  (wdt_tick)
  );

  assign wdt_tick_o = wdt_tick;

  // a wake reloads only the start-up counter, the reset delay never reruns
  assign su_load  = (state_ff == ST_LOAD) ||
                    ((state_ff == ST_SLEEP) && wake_req_i);
  assign dly_load = (state_ff == ST_LOAD);

  cssel_down_cnt #(
    .W (CNT_W)
  ) u_startup_cnt (
    .clock_i    (clock_i),
    .nrst_i     (nrst_i),
    .load_i     (su_load),
    .load_val_i (su_cnt),
    .tick_i     (source_tick_i),
    .done_o     (su_done),
    .count_o    ()
  );

  cssel_down_cnt #(
    .W (CNT_W)
  ) u_reset_dly_cnt (
    .clock_i    (clock_i),
    .nrst_i     (nrst_i),
    .load_i     (dly_load),
    .load_val_i (dly_cnt),
    .tick_i     (wdt_tick),
    .done_o     (dly_done),
    .count_o    ()
  );

  // ==========================================================================
  // sequencing
  // sleep or wake requests outside their own state are ignored
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_SAMPLE:     nxt_state = ST_LOAD;
      ST_LOAD:       nxt_state = ST_RESET_WAIT;
      ST_RESET_WAIT: begin
        if (su_done && dly_done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_req_i) begin
          nxt_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_req_i) begin
          nxt_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (su_done) begin
          nxt_state = ST_RUN;
        end
      end
      default:       nxt_state = ST_SAMPLE;
    endcase
  end

  assign core_clk_en_o = (state_ff == ST_RUN);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= ST_SAMPLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // fuses are captured once, in the first cycle after reset release
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clock_source_select_ff <= cssel_pkg::CKSRC_INT_RC_LO;
      sut_ff   <= cssel_pkg::SUT_10;
    end else if (state_ff == ST_SAMPLE) begin
      clock_source_select_ff <= clock_source_select_i;
      sut_ff   <= startup_time_select_i;
    end
  end

  // ==========================================================================
  // register port
  logic trim_sel;
  logic status_sel;
  logic fuse_sel;
  logic [7:0] status_val;
  logic [7:0] fuse_val;
  logic       trim_wr;

  assign trim_sel   = (reg_addr_i == ADDR_W'(cssel_pkg::REG_TRIM));
  assign status_sel = (reg_addr_i == ADDR_W'(cssel_pkg::REG_STATUS));
  assign fuse_sel   = (reg_addr_i == ADDR_W'(cssel_pkg::REG_FUSE));
  // writes to status, fuse and unmapped offsets are dropped
  assign trim_wr    = reg_wr_i && trim_sel;

  // live views only, no status bit is sticky
  always_comb begin
    status_val = 8'h00;
    status_val[cssel_pkg::ST_READY_BIT] = core_clk_en_o;
    status_val[cssel_pkg::ST_RSVD_BIT]  = cfg_rsvd;
    status_val[cssel_pkg::ST_MODE_LSB +: 3] = src_mode;
    status_val[cssel_pkg::ST_WAKE_BIT]  = (state_ff == ST_WAKE);
    status_val[cssel_pkg::ST_SLEEP_BIT] = (state_ff == ST_SLEEP);
    status_val[cssel_pkg::ST_RDLY_BIT]  = (state_ff == ST_RESET_WAIT) && !dly_done;
  end

  assign fuse_val = {2'h0, sut_ff, clock_source_select_ff};

  // factory byte overrides any write in the sample cycle; trim only
  // shifts frequency monotonically, the oscillator itself gives the range
  assign nxt_trim = (state_ff == ST_SAMPLE) ? factory_trim_i :
                    trim_wr                 ? reg_wdata_i : trim_ff;

  // zero except in the cycle after a read strobe
  assign nxt_rdata = !reg_rd_i  ? 8'h00      :
                     trim_sel   ? trim_ff    :
                     status_sel ? status_val :
                     fuse_sel   ? fuse_val   : 8'h00;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trim_ff  <= cssel_pkg::TRIM_RST;
      rdata_ff <= 8'h00;
    end else begin
      trim_ff  <= nxt_trim;
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata_o    = rdata_ff;
  assign trim_value_o   = trim_ff;
  assign source_mode_o  = src_mode;
  assign cfg_reserved_o = cfg_rsvd;

endmodule : cssel_clock_source_startup_select

`default_nettype wire

// ### cssel_props.sv
`timescale 1ns/100ps
`default_nettype none
module cssel_props #(
  parameter int SU_LONG_CK   = 32768,
  parameter int DLY_SHORT_CK = 4096,
  parameter int DLY_LONG_CK  = 65536
) (
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic [3:0] clock_source_select_i,
  input wire logic [1:0] startup_time_select_i,
  input wire logic [7:0] factory_trim_i,
  input wire logic       source_tick_i,
  input wire logic       sleep_req_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       core_clk_en_o,
  input wire logic [7:0] trim_value_o,
  input wire logic [2:0] source_mode_o,
  input wire logic       xtal_pins_free_o,
  input wire logic       wdt_tick_o,
  input wire logic       cfg_reserved_o
);
  // ==========
  // fuse shadow and tick counts since the core clock last stopped
  logic        rel_ff, boot_ff;
  logic [3:0]  src_ff;
  logic [1:0]  sut_ff;
  logic [17:0] su_ff, wd_ff;
  wire lf  = src_ff == 4'h9;
  wire erc = src_ff inside {[4'h5:4'h8]};
  wire irc = src_ff inside {[4'h1:4'h4]};
  wire xt  = src_ff > 4'h9;
  wire rsv = xt || (sut_ff == 2'h3 && !erc);
  wire [2:0] mode_exp = xt ? 3'h4 : lf ? 3'h3 : erc ? 3'h2 : irc ? 3'h1 : 3'h0;
  wire [31:0] su_exp = (lf && !sut_ff[1]) ? 1024 : (lf || xt) ? SU_LONG_CK :
                    (erc && sut_ff != 2'h3) ? 18 : 6;
  wire [31:0] dl_exp = sut_ff == 2'h0 ? ((lf) ? DLY_SHORT_CK : xt ? DLY_LONG_CK : 0) :
                    (sut_ff == 2'h1 || (erc && sut_ff == 2'h3)) && !lf && !xt ? DLY_SHORT_CK :
                    DLY_LONG_CK;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rel_ff  <= 1'b0;
      boot_ff <= 1'b1;
      src_ff  <= 4'h0;
      sut_ff  <= 2'h0;
      su_ff   <= 18'h0;
      wd_ff   <= 18'h0;
    end else begin
      rel_ff  <= 1'b1;
      src_ff  <= rel_ff ? src_ff : clock_source_select_i;
      sut_ff  <= rel_ff ? sut_ff : startup_time_select_i;
      boot_ff <= boot_ff & ~core_clk_en_o;
      su_ff   <= core_clk_en_o ? 18'h0 : su_ff + 18'(source_tick_i);
      wd_ff   <= core_clk_en_o ? 18'h0 : wd_ff + 18'(wdt_tick_o);
    end
  end

  // ==========
  // checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  rd_idle_a:
    assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("rdata not idle");
  trim_write_a:
    assert property (rel_ff && reg_wr_i && reg_addr_i == cssel_pkg::REG_TRIM
      |=> trim_value_o == $past(reg_wdata_i)) else $error("trim write lost");
  trim_hold_a:
    assert property (rel_ff && !reg_wr_i |=> $stable(trim_value_o)) else $error("trim moved");
  factory_load_a:
    assert property ($rose(rel_ff) |-> trim_value_o == $past(factory_trim_i))
      else $error("factory trim not loaded");
  fuse_read_a:
    assert property ($past(reg_rd_i && rel_ff) && $past(reg_addr_i) == cssel_pkg::REG_FUSE
      |-> reg_rdata_o == {2'h0, sut_ff, src_ff}) else $error("fuse read wrong");
  source_mode_a:
    assert property (rel_ff |-> source_mode_o == mode_exp) else $error("source mode wrong");
  pins_free_a:
    assert property (rel_ff |-> xtal_pins_free_o == irc) else $error("pins free wrong");
  reserved_cfg_a:
    assert property (rel_ff |-> cfg_reserved_o == rsv) else $error("reserved flag wrong");
  sleep_gate_a:
    assert property (core_clk_en_o && sleep_req_i |=> !core_clk_en_o) else $error("no gate");
  startup_cnt_a:
    assert property ($rose(core_clk_en_o) |-> su_ff >= su_exp) else $error("start-up short");
  reset_delay_a:
    assert property ($rose(core_clk_en_o) && boot_ff |-> wd_ff >= dl_exp)
      else $error("reset delay short");
endmodule : cssel_props

bind cssel_clock_source_startup_select cssel_props #(
  .SU_LONG_CK(SU_LONG_CK), .DLY_SHORT_CK(DLY_SHORT_CK), .DLY_LONG_CK(DLY_LONG_CK)
) i_props (
  .clock_i(clock_i), .nrst_i(nrst_i), .clock_source_select_i(clock_source_select_i),
  .startup_time_select_i(startup_time_select_i), .factory_trim_i(factory_trim_i),
  .source_tick_i(source_tick_i), .sleep_req_i(sleep_req_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .core_clk_en_o(core_clk_en_o), .trim_value_o(trim_value_o),
  .source_mode_o(source_mode_o), .xtal_pins_free_o(xtal_pins_free_o),
  .wdt_tick_o(wdt_tick_o), .cfg_reserved_o(cfg_reserved_o)
);
`default_nettype wire

// ### cssel_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module cssel_src_model (
  input  wire logic       clock_i,
  input  wire logic       run_i,
  input  wire logic [3:0] div_i,
  output logic            tick_o
);
  logic [3:0] cnt_ff = 4'h0;
  // fixed period: the source never steps its frequency between cycles
  always_ff @(posedge clock_i) begin
    cnt_ff <= (!run_i || cnt_ff >= div_i - 4'h1) ? 4'h0 : cnt_ff + 4'h1;
  end
  assign tick_o = run_i && cnt_ff == div_i - 4'h1;
endmodule : cssel_src_model
`default_nettype wire

// ### tb_clock_source_startup_select.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_clock_source_startup_select;
  localparam int SUL = 40, DS = 20, DL = 50, WD = 4;
  typedef struct {logic [3:0] s; logic [1:0] t; int su; int dl; logic r;} cssel_case_t;
  logic       clock_i, nrst_i, tick, slp, wak, wr_s, rd_s, en, pf, wt, rsv, run;
  logic [3:0] src, addr;
  logic [1:0] startup_time_select, rng;
  logic [7:0] ftrim, wd, rdata, trim;
  logic [2:0] mode;
  int         error_cnt = 0, checked = 0, n;
  cssel_case_t tbl [17] = '{'{4'h9,2'h0,1024,DS,0}, '{4'h9,2'h1,1024,DL,0},
    '{4'h9,2'h2,SUL,DL,0}, '{4'h9,2'h3,SUL,DL,1}, '{4'h5,2'h0,18,0,0}, '{4'h6,2'h1,18,DS,0},
    '{4'h7,2'h2,18,DL,0}, '{4'h8,2'h3,6,DS,0}, '{4'h1,2'h0,6,0,0}, '{4'h2,2'h1,6,DS,0},
    '{4'h3,2'h2,6,DL,0}, '{4'h4,2'h3,6,DL,1}, '{4'h0,2'h0,6,0,0}, '{4'h0,2'h1,6,DS,0},
    '{4'h0,2'h2,6,DL,0}, '{4'h0,2'h3,6,DL,1}, '{4'ha,2'h0,SUL,DL,1}};

  cssel_clock_source_startup_select #(.SU_LONG_CK(SUL), .DLY_SHORT_CK(DS),
    .DLY_LONG_CK(DL), .WDT_DIV(WD)) i_dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .clock_source_select_i(src),
    .startup_time_select_i(startup_time_select), .factory_trim_i(ftrim), .source_tick_i(tick),
    .sleep_req_i(slp), .wake_req_i(wak), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .core_clk_en_o(en),
    .trim_value_o(trim), .source_mode_o(mode), .freq_range_o(rng),
    .xtal_pins_free_o(pf), .wdt_tick_o(wt), .cfg_reserved_o(rsv));
  cssel_src_model i_src (.clock_i(clock_i), .run_i(run), .div_i(4'h2), .tick_o(tick));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // ==========
  // bus and sequence tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    rd_s <= 1'b0; wr_s <= 1'b1; addr <= a; wd <= d;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i);
    wr_s <= 1'b0; rd_s <= 1'b1; addr <= a;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask : rd
  task automatic wait_en(output int c);
    c = 0;
    while (en !== 1'b1 && c < 5000) begin
      @(posedge clock_i);
      #1 c++;
    end
  endtask : wait_en
  task automatic boot(input cssel_case_t k, input logic [7:0] f);
    int c;
    @(posedge clock_i);
    nrst_i <= 1'b0; src <= k.s; startup_time_select <= k.t; ftrim <= f;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    wait_en(c);
    n = (k.su * 2 > k.dl * WD) ? k.su * 2 : k.dl * WD;
    `CHK("startup", 1'b1, c >= n - 4 && c <= n + 12)
    `CHK("trim", f, trim)
    `CHK("reserved", k.r, rsv)
  endtask : boot
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    #200_000;
    error_cnt++;
    stop_test;
  end

  // ==========
  // tests
  initial begin
    nrst_i = 1'b0; wr_s = 1'b0; rd_s = 1'b0; addr = 4'h0; wd = 8'h00; slp = 1'b0;
    wak = 1'b0; src = 4'h1; startup_time_select = 2'h2; ftrim = 8'h00; run = 1'b1;
    foreach (tbl[i]) begin
      boot(tbl[i], 8'h5a ^ 8'(i));
      n = tbl[i].s inside {[4'h1:4'h8]} ? tbl[i].s - (tbl[i].s > 4'h4 ? 5 : 1) : 0;
      `CHK("range", 2'(n), rng)
      n = tbl[i].s == 4'h0 ? 0 : tbl[i].s < 4'h5 ? 1 : tbl[i].s < 4'h9 ? 2 :
          tbl[i].s == 4'h9 ? 3 : 4;
      `CHK("mode", 3'(n), mode)
      `CHK("pins", tbl[i].s inside {[4'h1:4'h4]}, pf)
      $display("test mode %0d done", i);
    end
    boot(tbl[6], 8'h3c);
    // no nonvolatile write is running, so the full trim range is allowed
    wr(cssel_pkg::REG_TRIM, 8'h00);
    wr(cssel_pkg::REG_TRIM, 8'hff);
    rd(cssel_pkg::REG_TRIM, 8'hff);
    wr(cssel_pkg::REG_TRIM, 8'h7f);
    wr(cssel_pkg::REG_FUSE, 8'h00);
    wr(cssel_pkg::REG_STATUS, 8'h00);
    rd(cssel_pkg::REG_TRIM, 8'h7f);
    @(posedge clock_i);
    src <= 4'h9;
    rd(cssel_pkg::REG_FUSE, 8'h27);
    rd(cssel_pkg::REG_STATUS, 8'h09);
    rd(4'hf, 8'h00);
    rd(4'h3, 8'h00);
    $display("test registers done");
    @(posedge clock_i);
    wak <= 1'b1;
    @(posedge clock_i);
    wak <= 1'b0; slp <= 1'b1;
    @(posedge clock_i);
    slp <= 1'b0;
    run <= 1'b0;
    #1 `CHK("gated", 1'b0, en)
    rd(cssel_pkg::REG_STATUS, 8'h48);
    n = 0;
    repeat (20) begin
      @(posedge clock_i);
      #1 n += int'(wt);
    end
    `CHK("wdt ticks", 20 / WD, n)
    @(posedge clock_i);
    wak <= 1'b1;
    run <= 1'b1;
    @(posedge clock_i);
    wak <= 1'b0;
    wait_en(n);
    `CHK("wake", 1'b1, n >= 28 && n <= 46)
    $display("test sleep done");
    boot(tbl[0], 8'ha5);
    $display("test trim reload done");
    stop_test;
  end
endmodule : tb_clock_source_startup_select
`default_nettype wire
